//--- hw/epiu_top.sv
// Pin interrupt unit: sensing, flags, enables, requests and AXI4-Lite registers.
//
// Summary of operation
// - Sense field picks low, change, fall, rise.
// - Line sampled by clock; pulses over a cycle count.
// - Line request needs enable bit 0 and global.
// - Line triggers even when pin is an output.
// - Enable bit 7 arms change group 1 requests.
// - Enable bit 6 arms change group 0 requests.
// - Change on enabled high pins sets flag 7.
// - Change on enabled low pins sets flag 6.
// - Line trigger event sets flag bit 0.
// - Vector entry clears the matching flag.
// - Writing one clears a flag; zero keeps.
// - Line flag reads zero in low-level mode.
// - High mask bits gate pins 15..8 changes.
// - Low mask bits gate pins 7..0 changes.
// - Pin-change detection needs the aclk sampling clock.
// - Low-level detection also needs the aclk sampling clock.
`timescale 1ns/1ps
`include "epiu_map.svh"
module epiu_top import epiu_pkg::*; #(
   parameter int PINS = 8    // Pins in each change group.
) (
   input  wire logic            aclk,               // System clock, 40 MHz.
   input  wire logic            aresetn,            // Synchronous reset, active low.
   input  wire logic            dedicated_irq_line, // Dedicated interrupt pin level.
   input  wire logic [PINS-1:0] change_pins_high,   // Change pins 15..8.
   input  wire logic [PINS-1:0] change_pins_low,    // Change pins 7..0.
   input  wire logic            global_irq_enable,  // Global flag of cpu_status_reg.
   input  wire epiu_pkg::epiu_src_t vector_ack,     // Pulse: vector entered.
   output epiu_pkg::epiu_src_t  requests,           // Requests to the vector logic.
   output logic                 irq,                // Any request pending.
   input  wire logic [11:0]     s_axi_awaddr,       // Write address.
   input  wire logic            s_axi_awvalid,      // Write address valid.
   output logic                 s_axi_awready,      // Write address ready.
   input  wire logic [31:0]     s_axi_wdata,        // Write data.
   input  wire logic [3:0]      s_axi_wstrb,        // Write byte strobes.
   input  wire logic            s_axi_wvalid,       // Write data valid.
   output logic                 s_axi_wready,       // Write data ready.
   output logic [1:0]           s_axi_bresp,        // Write response.
   output logic                 s_axi_bvalid,       // Write response valid.
   input  wire logic            s_axi_bready,       // Write response ready.
   input  wire logic [11:0]     s_axi_araddr,       // Read address.
   input  wire logic            s_axi_arvalid,      // Read address valid.
   output logic                 s_axi_arready,      // Read address ready.
   output logic [31:0]          s_axi_rdata,        // Read data.
   output logic [1:0]           s_axi_rresp,        // Read response.
   output logic                 s_axi_rvalid,       // Read data valid.
   input  wire logic            s_axi_rready        // Read data ready.
);
   // Sampler width and the two response codes used by the bus slave.

   localparam int  SW       = 2 * PINS + 1;  // Pins watched by the sampler.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ======
   // Declarations
   // ======
   logic [7:0]      ext_irq_flags;          // Sticky flags, bits 7, 6 and 0.
   logic [7:0]      ext_irq_enable_mask;    // Source enables, same layout.
   logic [7:0]      ext_irq_sense_control;  // Line sense field in bits 1:0.
   logic [PINS-1:0] pin_change_mask_low;    // Per-pin enables, pins 7..0.
   logic [PINS-1:0] pin_change_mask_high;   // Per-pin enables, pins 15..8.
   logic [7:0]      next_flags;             // Flag value for the next edge.
   logic [SW-1:0]   smp_level;              // Synchronised levels.
   logic [SW-1:0]   smp_change;             // Changes per pin.
   logic [SW-1:0]   smp_rise;               // Rising edges per pin.
   logic [SW-1:0]   smp_fall;               // Falling edges per pin.
   epiu_sense_t     sense;                  // Decoded line sense.
   logic            line_event;             // Line trigger event this cycle.
   logic            line_low;               // Synchronised line is low.
   logic            grp1_event;             // Unmasked change on pins 15..8.
   logic            grp0_event;             // Unmasked change on pins 7..0.
   epiu_src_t       next_req;               // Request value for the next edge.
   epiu_wr_state_t  wr_state;               // Write channel state.
   epiu_wr_state_t  next_wr_state;          // Next write channel state.
   logic            aw_held;                // Write address taken.
   logic            w_held;                 // Write data taken.
   logic            next_aw_held;           // Next value of aw_held.
   logic            next_w_held;            // Next value of w_held.
   logic [9:0]      aw_idx;                 // Held write register index.
   logic [7:0]      w_byte;                 // Held low write byte.
   logic            w_lane0;                // Held strobe of byte lane 0.
   logic            wr_do;                  // Perform the held write now.
   logic            wr_hit;                 // Held write index is mapped.

   // ======
   // Helper functions
   // ======
   // Tells whether a register index belongs to the block.
   function automatic logic idx_mapped(input logic [9:0] idx);
      idx_mapped = (idx == `EPIU_IDX_FLAGS) || (idx == `EPIU_IDX_ENABLE) ||
                   (idx == `EPIU_IDX_SENSE) || (idx == `EPIU_IDX_MASK_LOW) ||
                   (idx == `EPIU_IDX_MASK_HIGH);
   endfunction

   // Tells whether a held write targets the given index with lane 0 on.
   function automatic logic wr_to(input logic [9:0] idx);
      wr_to = wr_do && w_lane0 && (aw_idx == idx);
   endfunction

   // ======
   // Pin sampling
   // ======
   // The line pad is read whatever the pin direction, so software driving
   // the pin as an output still triggers the line.
   epiu_sync #(
      .W (SW)
   ) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin_in  ({dedicated_irq_line, change_pins_high, change_pins_low}),
      .level   (smp_level),
      .change  (smp_change),
      .rise    (smp_rise),
      .fall    (smp_fall)
   );

   // ======
   // Event detection
   // ======
   assign sense    = epiu_sense_t'(ext_irq_sense_control[1:0]);
   assign line_low = !smp_level[SW-1];

   // Selects the line trigger from the sense field.
   // Edges and the low level both come from the clocked sampler, so no path
   // stays usable for wake-up logic that gates this clock.
   always_comb begin
      unique case (sense)
         EPIU_SENSE_LOW:  line_event = 1'b0;
         EPIU_SENSE_ANY:  line_event = smp_change[SW-1];
         EPIU_SENSE_FALL: line_event = smp_fall[SW-1];
         EPIU_SENSE_RISE: line_event = smp_rise[SW-1];
      endcase
   end

   // Per-pin masks gate changes before the group OR; detection depends on
   // no pin clock, only on the sampling clock of this block.
   assign grp1_event = |(smp_change[2*PINS-1:PINS] & pin_change_mask_high);
   assign grp0_event = |(smp_change[PINS-1:0] & pin_change_mask_low);

   // ======
   // Interrupt flags
   // ======
   // Clears by write of one or by vector entry; a set in the same cycle wins.
   always_comb begin
      next_flags = ext_irq_flags;
      if (wr_to(`EPIU_IDX_FLAGS)) begin
         next_flags = next_flags & ~w_byte;
      end
      if (vector_ack.group1) begin
         next_flags[`EPIU_BIT_GROUP1] = 1'b0;
      end
      if (vector_ack.group0) begin
         next_flags[`EPIU_BIT_GROUP0] = 1'b0;
      end
      if (vector_ack.line) begin
         next_flags[`EPIU_BIT_LINE] = 1'b0;
      end
      if (grp1_event) begin
         next_flags[`EPIU_BIT_GROUP1] = 1'b1;
      end
      if (grp0_event) begin
         next_flags[`EPIU_BIT_GROUP0] = 1'b1;
      end
      if (line_event) begin
         next_flags[`EPIU_BIT_LINE] = 1'b1;
      end
      if (sense == EPIU_SENSE_LOW) begin
         next_flags[`EPIU_BIT_LINE] = 1'b0;
      end
      next_flags = next_flags & `EPIU_FLAGS_USED;
   end

   // Stores the flags.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_irq_flags <= `EPIU_RST_REG;
      end else begin
         ext_irq_flags <= next_flags;
      end
   end

   // ======
   // Requests to the vector logic
   // ======
   // Each source needs its enable bit and the global flag.
   always_comb begin
      next_req.group1 = ext_irq_flags[`EPIU_BIT_GROUP1] &
                        ext_irq_enable_mask[`EPIU_BIT_GROUP1] & global_irq_enable;
      next_req.group0 = ext_irq_flags[`EPIU_BIT_GROUP0] &
                        ext_irq_enable_mask[`EPIU_BIT_GROUP0] & global_irq_enable;
      // In low-level mode the request follows the line and stays only while
      // the driver keeps it low.
      if (sense == EPIU_SENSE_LOW) begin
         next_req.line = line_low;
      end else begin
         next_req.line = ext_irq_flags[`EPIU_BIT_LINE];
      end
      next_req.line = next_req.line & ext_irq_enable_mask[`EPIU_BIT_LINE] &
                      global_irq_enable;
   end

   // Registers the requests and the summary output.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         requests <= '0;
         irq      <= 1'b0;
      end else begin
         requests <= next_req;
         irq      <= |next_req;
      end
   end

   // ======
   // Control registers
   // ======
   // Software writes the enables, sense field and pin masks through lane 0.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_irq_enable_mask   <= `EPIU_RST_REG;
         ext_irq_sense_control <= `EPIU_RST_REG;
         pin_change_mask_low   <= '0;
         pin_change_mask_high  <= '0;
      end else begin
         if (wr_to(`EPIU_IDX_ENABLE)) begin
            ext_irq_enable_mask <= w_byte & `EPIU_FLAGS_USED;
         end
         if (wr_to(`EPIU_IDX_SENSE)) begin
            ext_irq_sense_control <= w_byte & `EPIU_SENSE_USED;
         end
         if (wr_to(`EPIU_IDX_MASK_LOW)) begin
            pin_change_mask_low <= w_byte[PINS-1:0];
         end
         if (wr_to(`EPIU_IDX_MASK_HIGH)) begin
            pin_change_mask_high <= w_byte[PINS-1:0];
         end
      end
   end

   // ======
   // AXI4-Lite write channel
   // ======
   assign wr_do  = (wr_state == EPIU_WR_IDLE) && aw_held && w_held;
   assign wr_hit = idx_mapped(aw_idx);

   // Address and data are taken in either order, then written together.
   always_comb begin
      next_aw_held  = aw_held | (s_axi_awvalid & s_axi_awready);
      next_w_held   = w_held | (s_axi_wvalid & s_axi_wready);
      next_wr_state = wr_state;
      unique case (wr_state)
         EPIU_WR_IDLE: begin
            if (wr_do) begin
               next_wr_state = EPIU_WR_RESP;
               next_aw_held  = 1'b0;
               next_w_held   = 1'b0;
            end
         end
         EPIU_WR_RESP: begin
            if (s_axi_bready) begin
               next_wr_state = EPIU_WR_IDLE;
            end
         end
      endcase
   end

   // Holds the write channel state and handshake outputs.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state      <= EPIU_WR_IDLE;
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         wr_state      <= next_wr_state;
         aw_held       <= next_aw_held;
         w_held        <= next_w_held;
         s_axi_awready <= !next_aw_held && (next_wr_state == EPIU_WR_IDLE);
         s_axi_wready  <= !next_w_held && (next_wr_state == EPIU_WR_IDLE);
         if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Captures the write address and data as each is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_idx  <= '0;
         w_byte  <= '0;
         w_lane0 <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_idx <= s_axi_awaddr[11:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_byte  <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
         end
      end
   end

   // ======
   // AXI4-Lite read channel
   // ======
   // Reads have no side effect; unused upper bits read zero.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= idx_mapped(s_axi_araddr[11:2]) ? RESP_OKAY : RESP_SLVERR;
         unique case (s_axi_araddr[11:2])
            `EPIU_IDX_FLAGS:     s_axi_rdata <= {24'h0, ext_irq_flags};
            `EPIU_IDX_ENABLE:    s_axi_rdata <= {24'h0, ext_irq_enable_mask};
            `EPIU_IDX_SENSE:     s_axi_rdata <= {24'h0, ext_irq_sense_control};
            `EPIU_IDX_MASK_LOW:  s_axi_rdata <= {{(32-PINS){1'b0}}, pin_change_mask_low};
            `EPIU_IDX_MASK_HIGH: s_axi_rdata <= {{(32-PINS){1'b0}}, pin_change_mask_high};
            default:             s_axi_rdata <= 32'h0000_0000;
         endcase
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

endmodule

//--- hw/epiu_map.svh
// Register indices, field positions, reset values and timing counts of the pin interrupt unit.
`ifndef EPIU_MAP_SVH
`define EPIU_MAP_SVH

// ======
// Register indices (byte address is four times the index)
`define EPIU_IDX_FLAGS     10'h01C
`define EPIU_IDX_ENABLE    10'h01D
`define EPIU_IDX_SENSE     10'h069
`define EPIU_IDX_MASK_LOW  10'h06B
`define EPIU_IDX_MASK_HIGH 10'h06C

// ======
// Field positions
`define EPIU_BIT_GROUP1    7
`define EPIU_BIT_GROUP0    6
`define EPIU_BIT_LINE      0
`define EPIU_FLAGS_USED    8'hC1
`define EPIU_SENSE_USED    8'h03

// ======
// Reset values
`define EPIU_RST_REG       8'h00

// ======
// Timing counts
`define EPIU_SYNC_ARM      2'h2

`endif

//--- hw/epiu_pkg.sv
// Types shared by the pin interrupt unit.
package epiu_pkg;

   // Line trigger selection held in the sense field.
   typedef enum logic [1:0] {
      EPIU_SENSE_LOW  = 2'h0,
      EPIU_SENSE_ANY  = 2'h1,
      EPIU_SENSE_FALL = 2'h2,
      EPIU_SENSE_RISE = 2'h3
   } epiu_sense_t;

   // One bit for each interrupt source, used for requests and acknowledges.
   typedef struct packed {
      logic group1;
      logic group0;
      logic line;
   } epiu_src_t;

   // Write channel state of the bus slave.
   typedef enum logic {
      EPIU_WR_IDLE = 1'b0,
      EPIU_WR_RESP = 1'b1
   } epiu_wr_state_t;

endpackage

//--- hw/epiu_sync.sv
// Pin sampler: two-stage synchroniser, previous sample and change detection.
`timescale 1ns/1ps
module epiu_sync import epiu_pkg::*; #(
   parameter int W = 17
) (
   input  wire logic         aclk,     // System clock.
   input  wire logic         aresetn,  // Synchronous reset, active low.
   input  wire logic [W-1:0] pin_in,   // Raw pin levels.
   output logic      [W-1:0] level,    // Synchronised pin levels.
   output logic      [W-1:0] change,   // Any change since the previous sample.
   output logic      [W-1:0] rise,     // Low to high since the previous sample.
   output logic      [W-1:0] fall      // High to low since the previous sample.
);

   logic [W-1:0] meta;   // First stage, read only by the second stage.
   logic [W-1:0] prev;   // Previous synchronised sample.
   logic [1:0]   arm;    // Counts stages filled since reset.
   logic         armed;  // Sampler holds real pin values.

   // ======
   // Sampling chain
   // The pins are sampled by the clock before any edge is looked at.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta  <= '0;
         level <= '0;
         prev  <= '0;
      end else begin
         meta  <= pin_in;
         level <= meta;
         prev  <= level;
      end
   end

   // Holds off detection two cycles, one short of the full chain, so a pin high at reset still shows one change.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arm <= 2'h0;
      end else if (arm != `EPIU_SYNC_ARM) begin
         arm <= arm + 2'h1;
      end
   end

   assign armed  = (arm == `EPIU_SYNC_ARM);
   // A change is a difference between the current and previous sample.
   assign change = (level ^ prev) & {W{armed}};
   assign rise   = change & level;
   assign fall   = change & prev;

endmodule

//--- tb/epiu_checker_properties.sv
// Port checker of the pin interrupt unit, bound to its top module.
`timescale 1ns/1ps
module epiu_checker import epiu_pkg::*; #(
   parameter int PINS = 8                        // Pins in each change group.
) (
   input wire logic            aclk,              // System clock.
   input wire logic            aresetn,           // Reset, active low.
   input wire logic            global_irq_enable, // Global enable.
   input wire epiu_src_t       vector_ack,        // Vector entry pulses.
   input wire epiu_src_t       requests,          // Requests to the vectors.
   input wire logic            irq,               // Summary interrupt.
   input wire logic [PINS-1:0] change_pins_low,   // Pins 7..0.
   input wire logic            s_axi_awready,     // Write address ready.
   input wire logic            s_axi_bvalid,      // Write response valid.
   input wire logic            s_axi_bready,      // Write response ready.
   input wire logic [1:0]      s_axi_bresp,       // Write response.
   input wire logic            s_axi_rvalid,      // Read data valid.
   input wire logic            s_axi_rready,      // Read data ready.
   input wire logic [31:0]     s_axi_rdata        // Read data.
);
   // ======
   // Properties, all on the one clock and reset.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // The summary output mirrors the request vector.
   property p_irq_sum; irq == (requests != 3'h0); endproperty
   a_irq_sum: assert property (p_irq_sum) else $error("irq disagrees with requests");
   // Without the global flag no request may stand one cycle later.
   property p_global; !global_irq_enable |=> requests == 3'h0; endproperty
   a_global: assert property (p_global) else $error("request without global flag");
   // A group 1 request stays while nothing can clear its flag or enable.
   property p_sticky;
      requests.group1 && global_irq_enable && $past(s_axi_awready)
      && !$past(vector_ack.group1) |=> requests.group1;
   endproperty
   a_sticky: assert property (p_sticky) else $error("group1 request lost");
   // Vector entry with quiet pins drops the group 0 request two edges on.
   property p_ack;
      $stable(change_pins_low)[*4] ##0 vector_ack.group0 |-> ##2 !requests.group0;
   endproperty
   a_ack: assert property (p_ack) else $error("ack left group0 request");
   // Leaving reset finds the requests, irq and the write response valid cleared.
   property p_reset; $rose(aresetn) |-> requests == 3'h0 && !irq && !s_axi_bvalid; endproperty
   a_reset: assert property (p_reset) else $error("outputs not clear after reset");
   // Registers are one byte wide, so upper read bits are zero.
   property p_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   // A write answer stands unchanged until it is taken.
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   // A read answer stands unchanged until it is taken.
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped");
   c_group0: cover property (requests.group0);
   c_line: cover property (requests.line);
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind epiu_top epiu_checker #(.PINS(PINS)) u_chk (.aclk, .aresetn, .global_irq_enable,
   .vector_ack, .requests, .irq, .change_pins_low, .s_axi_awready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

//--- tb/epiu_pin_model.sv
// Behavioural model of the external pins feeding the pin interrupt unit.
`timescale 1ns/1ps
module epiu_pin_model (
   input  wire logic  aclk,               // System clock.
   output logic       dedicated_irq_line, // Line pad level, read whatever its direction.
   output logic [7:0] change_pins_high,   // Pins 15..8.
   output logic [7:0] change_pins_low     // Pins 7..0.
);
   // Pins idle with the line high so that low-level sensing stays quiet.
   initial begin
      dedicated_irq_line = 1'b1;
      change_pins_high = 8'h00;
      change_pins_low = 8'h00;
   end
   // Moves pins just after an edge, holds them six cycles until requests show.
   task automatic drive(input logic l, input logic [7:0] hi, input logic [7:0] lo);
      @(posedge aclk);
      dedicated_irq_line <= l;
      change_pins_high <= hi;
      change_pins_low <= lo;
      repeat (6) @(posedge aclk);
   endtask
endmodule

//--- tb/tb_top.sv
// Self-checking testbench of the pin interrupt unit.
`timescale 1ns/1ps
`include "epiu_map.svh"
module tb_top import epiu_pkg::*; ();
   typedef struct packed {logic [11:0] a; logic [7:0] wd; logic [7:0] rd; logic [1:0] rs;} epiu_row_t;
   localparam logic [11:0] A_FLG = {`EPIU_IDX_FLAGS, 2'h0};     // Flags.
   localparam logic [11:0] A_EN  = {`EPIU_IDX_ENABLE, 2'h0};    // Enables.
   localparam logic [11:0] A_SNS = {`EPIU_IDX_SENSE, 2'h0};     // Sense field.
   localparam logic [11:0] A_ML  = {`EPIU_IDX_MASK_LOW, 2'h0};  // Low mask.
   localparam logic [11:0] A_MH  = {`EPIU_IDX_MASK_HIGH, 2'h0}; // High mask.
   logic aclk, aresetn, global_irq_enable, dedicated_irq_line, irq;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [7:0]  change_pins_high, change_pins_low;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   epiu_src_t   vector_ack, requests;
   int          failures, total_checks, cycles;
   // Register cases: reset read, write, response and read-back.
   epiu_row_t   rows [6] = '{'{A_EN, 8'hFF, 8'hC1, 2'h0}, '{A_SNS, 8'hFF, 8'h03, 2'h0},
      '{A_ML, 8'hA5, 8'hA5, 2'h0}, '{A_MH, 8'h5A, 8'h5A, 2'h0},
      '{A_FLG, 8'hFF, 8'h00, 2'h0}, '{12'h004, 8'hFF, 8'h00, 2'h2}};
   epiu_top DUT (.aclk, .aresetn, .dedicated_irq_line, .change_pins_high, .change_pins_low,
      .global_irq_enable, .vector_ack, .requests, .irq, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   epiu_pin_model u_pins (.aclk, .dedicated_irq_line, .change_pins_high, .change_pins_low);
   // ======
   // Clock, watchdog and shared tasks
   always #12.5 aclk = ~aclk;
   // A hang is counted as a mismatch and ends the run.
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         failures++;
         $display("[ERR] watchdog expected finish seen hang");
         close_out();
      end
   end
   // Compares one value against its expectation.
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Bus write: address and data offered together, each released when taken.
   task automatic axi_write(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
   endtask
   // Bus read: address held until taken, data taken with rvalid.
   task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic close_out();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ======
   // Main sequence
   initial begin
      {aclk, aresetn, global_irq_enable, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
      {vector_ack, s_axi_awaddr, s_axi_araddr, s_axi_wdata, failures, total_checks, cycles} = '0;
      {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      foreach (rows[i]) begin
         axi_read(rows[i].a, rd, rs);
         check("reset value", rd, 32'h0);
         axi_write(rows[i].a, rows[i].wd, rs);
         check("write resp", {30'h0, rs}, {30'h0, rows[i].rs});
         axi_read(rows[i].a, rd, rs);
         check("read back", rd, {24'h0, rows[i].rd});
         check("read resp", {30'h0, rs}, {30'h0, rows[i].rs});
         axi_write(rows[i].a, 8'h00, rs);
      end
      $display("test registers done");
      axi_write(A_ML, 8'h01, rs);
      axi_write(A_EN, 8'h40, rs);
      global_irq_enable <= 1'b1;
      u_pins.drive(1'b1, 8'h00, 8'h02);
      check("masked pin", {29'h0, requests}, 32'h0);
      u_pins.drive(1'b1, 8'h00, 8'h03);
      check("group0 request", {28'h0, irq, requests}, 32'hA);
      axi_read(A_FLG, rd, rs);
      check("group0 flag", rd, 32'h40);
      vector_ack <= 3'h2;
      @(posedge aclk);
      vector_ack <= 3'h0;
      repeat (3) @(posedge aclk);
      check("ack clears", {29'h0, requests}, 32'h0);
      $display("test group0 done");
      axi_write(A_MH, 8'h80, rs);
      axi_write(A_EN, 8'h80, rs);
      u_pins.drive(1'b1, 8'h80, 8'h03);
      check("group1 request", {29'h0, requests}, 32'h4);
      global_irq_enable <= 1'b0;
      repeat (2) @(posedge aclk);
      check("global gate", {29'h0, requests}, 32'h0);
      axi_write(A_FLG, 8'h40, rs);
      axi_read(A_FLG, rd, rs);
      check("zero keeps flag", rd, 32'h80);
      axi_write(A_FLG, 8'h80, rs);
      axi_read(A_FLG, rd, rs);
      check("one clears flag", rd, 32'h0);
      $display("test group1 done");
      axi_write(A_EN, 8'h01, rs);
      global_irq_enable <= 1'b1;
      for (int s = 1; s < 4; s++) begin
         axi_write(A_SNS, s[7:0], rs);
         u_pins.drive(1'b0, 8'h80, 8'h03);
         axi_read(A_FLG, rd, rs);
         check("fall flag", rd, {31'h0, s != 3});
         axi_write(A_FLG, 8'h01, rs);
         u_pins.drive(1'b1, 8'h80, 8'h03);
         axi_read(A_FLG, rd, rs);
         check("rise flag", rd, {31'h0, s != 2});
         axi_write(A_FLG, 8'h01, rs);
      end
      axi_write(A_SNS, 8'h00, rs);
      u_pins.drive(1'b0, 8'h80, 8'h03);
      check("level request", {29'h0, requests}, 32'h1);
      axi_read(A_FLG, rd, rs);
      check("level flag", rd, 32'h0);
      u_pins.drive(1'b1, 8'h80, 8'h03);
      check("level release", {29'h0, requests}, 32'h0);
      $display("test line done");
      close_out();
   end
endmodule
